/* File: hdl/sfsr_pkg.sv */
// Notes on behaviour
// [R1] Three eight-bit status registers hold bits 0-7, 8-15 and 16-23.
// [R2] A status write carrying the stored value changes nothing.
// [R3] Bit 0 is a read-only busy flag, 1 during any write cycle.
// [R4] Bit 1 is the volatile write-enable latch, default 0.
// [R5] Bits 2-6 are block protection, with volatile and non-volatile copies.
// [R6] Bits 7 and 8 select the write-protection method, default 0.
// [R7] Bit 9 is quad enable, volatile and non-volatile, default 0.
// [R8] Bit 10 reads 1 while a program is suspended.
// [R9] Bits 11-13 are one-time lock bits; once 1, they cannot be cleared.
// [R10] Bit 15 flags erase suspended; bit 14 is complement protect, default 0.
// [R11] Bit 18 sets when program or erase hits a protected area.
// [R12] Bit 19 sets when a program or erase fails, else 0.
// [R13] Bits 21-22 set drive strength, default bit 22 set, bit 21 clear.
// [R14] Bit 23 selects hold (0) or hardware reset (1) on the shared pin.
// [R15] Only the enable command sets the latch; disable, completed writes and resets clear it.
// [R16] While busy only status read, reset and suspend are obeyed.
// [R17] Suspend sets the matching suspended flag; resume clears it.
// [R18] Power-on, hardware and software reset clear the protection error flag.
// [R19] Reserved bits 16, 17 and 20 read zero, writes ignored.
// [R20] The host polls busy before issuing other commands.
package sfsr_pkg;

	// ==========================================================
	// timing
	localparam int SFSR_CLK_MHZ        = 25;
	localparam int SFSR_WRITE_TIME_US  = 5000;
	localparam int SFSR_WRITE_CYCLES   = SFSR_WRITE_TIME_US * SFSR_CLK_MHZ;
	localparam int SFSR_WCNT_W         = 18;

	// ==========================================================
	// commands
	localparam logic [7:0] SFSR_CMD_READ_LOW        = 8'h05;
	localparam logic [7:0] SFSR_CMD_READ_MID        = 8'h35;
	localparam logic [7:0] SFSR_CMD_READ_HIGH       = 8'h15;
	localparam logic [7:0] SFSR_CMD_WRITE_LOW       = 8'h01;
	localparam logic [7:0] SFSR_CMD_WRITE_MID       = 8'h31;
	localparam logic [7:0] SFSR_CMD_WRITE_HIGH      = 8'h11;
	localparam logic [7:0] SFSR_CMD_WRITE_ENABLE    = 8'h06;
	localparam logic [7:0] SFSR_CMD_WRITE_DISABLE   = 8'h04;
	localparam logic [7:0] SFSR_CMD_VOLATILE_ENABLE = 8'h50;
	localparam logic [7:0] SFSR_CMD_RESET_ENABLE    = 8'h66;
	localparam logic [7:0] SFSR_CMD_RESET           = 8'h99;
	localparam logic [7:0] SFSR_CMD_SUSPEND         = 8'h75;
	localparam logic [7:0] SFSR_CMD_RESUME          = 8'h7A;

	// ==========================================================
	// bit positions in the 24-bit status word
	localparam int SFSR_BIT_BUSY     = 0;
	localparam int SFSR_BIT_WR_LATCH = 1;
	localparam int SFSR_BIT_BP_LSB   = 2;
	localparam int SFSR_BIT_SRP_LSB  = 7;
	localparam int SFSR_BIT_QUAD     = 9;
	localparam int SFSR_BIT_PROG_SUS = 10;
	localparam int SFSR_BIT_IRL_LSB  = 11;
	localparam int SFSR_BIT_COMPL    = 14;
	localparam int SFSR_BIT_ERAS_SUS = 15;
	localparam int SFSR_BIT_PROT_HIT = 18;
	localparam int SFSR_BIT_OP_FAIL  = 19;
	localparam int SFSR_BIT_ODS_LSB  = 21;
	localparam int SFSR_BIT_HOLD_RST = 23;

	// ==========================================================
	// reset value and masks
	localparam logic [23:0] SFSR_STATUS_RESET = 24'h400000;
	localparam logic [23:0] SFSR_WRITE_MASK   = 24'hE07BFC;
	localparam logic [23:0] SFSR_DUAL_MASK    = 24'h00027C;
	localparam logic [23:0] SFSR_OTP_MASK     = 24'h003800;
	localparam logic [23:0] SFSR_VOL_CLR_MASK = 24'h0C8402;

	typedef enum logic [2:0] {
		SFSR_FR_IDLE,
		SFSR_FR_CMD,
		SFSR_FR_DATA,
		SFSR_FR_READ,
		SFSR_FR_HOLD,
		SFSR_FR_SKIP
	} sfsr_frame_e;

	// register lane of a read or write command, 3 when none
	function automatic logic [1:0] sfsr_lane(input logic [7:0] cmd);
		logic [1:0] l;
		l = 2'h3;
		if (cmd == SFSR_CMD_READ_LOW || cmd == SFSR_CMD_WRITE_LOW) begin
			l = 2'h0;
		end else if (cmd == SFSR_CMD_READ_MID || cmd == SFSR_CMD_WRITE_MID) begin
			l = 2'h1;
		end else if (cmd == SFSR_CMD_READ_HIGH
				|| cmd == SFSR_CMD_WRITE_HIGH) begin
			l = 2'h2;
		end
		return l;
	endfunction

	function automatic logic [23:0] sfsr_place(input logic [7:0] b,
			input logic [1:0] lane);
		logic [23:0] w;
		case (lane)
			2'h0: w = {16'h0000, b};
			2'h1: w = {8'h00, b, 8'h00};
			2'h2: w = {b, 16'h0000};
			default: w = 24'h000000;
		endcase
		return w;
	endfunction

endpackage

/* File: hdl/sfsr_link_if.sv */
interface sfsr_link_if;
	logic       frame_start;
	logic       frame_end;
	logic       rx_valid;
	logic [7:0] rx_byte;
	logic       tx_en;
	logic [7:0] tx_byte;

	modport link (
		output frame_start,
		output frame_end,
		output rx_valid,
		output rx_byte,
		input  tx_en,
		input  tx_byte
	);

	modport core (
		input  frame_start,
		input  frame_end,
		input  rx_valid,
		input  rx_byte,
		output tx_en,
		output tx_byte
	);
endinterface

/* File: hdl/sfsr_spi_link.sv */
module sfsr_spi_link (
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       nrst_i,
	// serial pins
	input  wire logic       sck_i,
	input  wire logic       cs_n_i,
	input  wire logic       si_i,
	output logic            so_o,
	output logic            so_oe_o,
	// to the register core
	sfsr_link_if.link       lnk
);
	import sfsr_pkg::*;

	// ==========================================================
	// synchronisers: only the second stage feeds logic
	logic [1:0] sck_s_q, cs_s_q, si_s_q;
	logic       sck_prev_q, cs_prev_q;

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			sck_s_q    <= 2'h0;
			cs_s_q     <= 2'h3;
			si_s_q     <= 2'h0;
			sck_prev_q <= 1'b0;
			cs_prev_q  <= 1'b1;
		end else begin
			sck_s_q    <= {sck_s_q[0], sck_i};
			cs_s_q     <= {cs_s_q[0], cs_n_i};
			si_s_q     <= {si_s_q[0], si_i};
			sck_prev_q <= sck_s_q[1];
			cs_prev_q  <= cs_s_q[1];
		end
	end

	// ==========================================================
	// shift engine, mode 0: sample on rise, launch on fall
	logic       act, rise, fall;
	logic [2:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d, rxb_q, rxb_d;
	logic       rxv_q, rxv_d, fs_q, fs_d, fe_q, fe_d, so_q, so_d;

	assign act  = ~cs_s_q[1];
	assign rise = act & sck_s_q[1] & ~sck_prev_q;
	assign fall = act & ~sck_s_q[1] & sck_prev_q;

	always_comb begin
		bit_d = bit_q;
		sh_d  = sh_q;
		rxb_d = rxb_q;
		rxv_d = 1'b0;
		so_d  = so_q;
		fs_d  = cs_prev_q & ~cs_s_q[1];
		fe_d  = ~cs_prev_q & cs_s_q[1];
		if (fs_d) begin
			bit_d = 3'h0;
			so_d  = 1'b0;
		end else if (rise) begin
			sh_d  = {sh_q[6:0], si_s_q[1]};
			bit_d = bit_q + 3'h1;
			if (bit_q == 3'h7) begin
				rxv_d = 1'b1;
				rxb_d = sh_d;
			end
		end else if (fall) begin
			so_d = lnk.tx_byte[~bit_q];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			bit_q <= 3'h0;
			sh_q  <= 8'h00;
			rxb_q <= 8'h00;
			rxv_q <= 1'b0;
			fs_q  <= 1'b0;
			fe_q  <= 1'b0;
			so_q  <= 1'b0;
		end else begin
			bit_q <= bit_d;
			sh_q  <= sh_d;
			rxb_q <= rxb_d;
			rxv_q <= rxv_d;
			fs_q  <= fs_d;
			fe_q  <= fe_d;
			so_q  <= so_d;
		end
	end

	assign lnk.frame_start = fs_q;
	assign lnk.frame_end   = fe_q;
	assign lnk.rx_valid    = rxv_q;
	assign lnk.rx_byte     = rxb_q;
	assign so_o            = so_q;
	assign so_oe_o         = lnk.tx_en & act;
endmodule

/* File: hdl/sfsr_top.sv */
module sfsr_top #(
	parameter int unsigned WRITE_CYCLES = sfsr_pkg::SFSR_WRITE_CYCLES
) (
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       nrst_i,
	// serial pins
	input  wire logic       sck_i,
	input  wire logic       cs_n_i,
	input  wire logic       si_i,
	output logic            so_o,
	output logic            so_oe_o,
	input  wire logic       hold_rst_n_i,
	// array engine events
	input  wire logic       op_start_i,
	input  wire logic       op_erase_i,
	input  wire logic       op_done_i,
	input  wire logic       op_fail_i,
	input  wire logic       prot_hit_i,
	// array engine controls
	output logic            busy_o,
	output logic            write_enable_latch_o,
	output logic [4:0]      block_protect_o,
	output logic [1:0]      status_protect_o,
	output logic            quad_enable_o,
	output logic [2:0]      info_lock_o,
	output logic            complement_protect_o,
	output logic [1:0]      drive_strength_o,
	output logic            hold_reset_sel_o,
	output logic            suspend_o,
	output logic            resume_o,
	output logic            soft_reset_o
);
	import sfsr_pkg::*;

	sfsr_link_if lnk ();

	sfsr_spi_link u_link (
		.clk_sys_i (clk_sys_i),
		.nrst_i    (nrst_i),
		.sck_i     (sck_i),
		.cs_n_i    (cs_n_i),
		.si_i      (si_i),
		.so_o      (so_o),
		.so_oe_o   (so_oe_o),
		.lnk       (lnk.link)
	);

	// ==========================================================
	// hardware reset pin synchroniser
	logic [1:0] hr_s_q;

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			hr_s_q <= 2'h3;
		end else begin
			hr_s_q <= {hr_s_q[0], hold_rst_n_i};
		end
	end

	// ==========================================================
	// state
	sfsr_frame_e            fr_q, fr_d;
	logic [7:0]             cmd_q, cmd_d, dat_q, dat_d, txb_q, txb_d;
	logic                   dok_q, dok_d, txe_q, txe_d;
	logic                   vwe_q, vwe_d, rsten_q, rsten_d;
	logic [23:0]            st_q, st_d, nv_q, nv_d;
	logic                   nvb_q, nvb_d, arb_q, arb_d, are_q, are_d;
	logic [SFSR_WCNT_W-1:0] cnt_q, cnt_d;
	logic                   sus_q, sus_d, res_q, res_d, srst_q, srst_d;

	logic        busy, hw_rst;
	logic [23:0] word;
	logic [1:0]  lane;

	assign busy   = nvb_q | arb_q;                          // see [R3]
	// reserved bits are never written so they stay zero  // see [R19]
	assign word   = st_q | {23'h000000, busy};              // see [R1]
	assign lane   = sfsr_lane(cmd_q);
	// pin acts as reset only when selected and quad mode is off // see [R14]
	assign hw_rst = ~hr_s_q[1] & st_q[SFSR_BIT_HOLD_RST] & ~st_q[SFSR_BIT_QUAD];

	always_comb begin
		logic [23:0] lmask, cand;
		logic [7:0]  rsel;
		logic [1:0]  rl;
		lmask  = 24'h000000;
		cand   = 24'h000000;
		rsel   = 8'h00;
		rl     = 2'h3;
		fr_d   = fr_q;
		cmd_d  = cmd_q;
		dat_d  = dat_q;
		dok_d  = dok_q;
		txe_d  = txe_q;
		txb_d  = txb_q;
		vwe_d  = vwe_q;
		rsten_d = rsten_q;
		st_d   = st_q;
		nv_d   = nv_q;
		nvb_d  = nvb_q;
		arb_d  = arb_q;
		are_d  = are_q;
		cnt_d  = cnt_q;
		sus_d  = 1'b0;
		res_d  = 1'b0;
		srst_d = 1'b0;

		// non-volatile write cycle timer
		if (nvb_q) begin
			if (cnt_q == '0) begin
				nvb_d = 1'b0;
				st_d[SFSR_BIT_WR_LATCH] = 1'b0;         // see [R15]
			end else begin
				cnt_d = cnt_q - 1'b1;
			end
		end

		// array engine events; failure flag follows each operation
		if (op_start_i) begin
			arb_d = 1'b1;
			are_d = op_erase_i;
			st_d[SFSR_BIT_OP_FAIL] = 1'b0;
		end
		if (op_done_i) begin
			arb_d = 1'b0;                               // see [R16]
			st_d[SFSR_BIT_WR_LATCH] = 1'b0;             // see [R15]
			st_d[SFSR_BIT_OP_FAIL] = op_fail_i;         // see [R12]
		end

		// frame decoding
		if (lnk.frame_start) begin
			fr_d  = SFSR_FR_CMD;
			dok_d = 1'b0;
			txe_d = 1'b0;
		end else if (lnk.rx_valid) begin
			case (fr_q)
				SFSR_FR_CMD: begin
					cmd_d = lnk.rx_byte;
					rl    = sfsr_lane(lnk.rx_byte);
					if (lnk.rx_byte == SFSR_CMD_READ_LOW
							|| lnk.rx_byte == SFSR_CMD_READ_MID
							|| lnk.rx_byte == SFSR_CMD_READ_HIGH) begin
						fr_d  = SFSR_FR_READ;
						txe_d = 1'b1;
					end else if (busy
							&& lnk.rx_byte != SFSR_CMD_RESET_ENABLE
							&& lnk.rx_byte != SFSR_CMD_RESET
							&& lnk.rx_byte != SFSR_CMD_SUSPEND) begin
						fr_d = SFSR_FR_SKIP;            // see [R16]
					end else if (rl != 2'h3) begin
						fr_d = SFSR_FR_DATA;
					end else begin
						fr_d = SFSR_FR_HOLD;
					end
				end
				SFSR_FR_DATA: begin
					dat_d = lnk.rx_byte;
					dok_d = 1'b1;
					fr_d  = SFSR_FR_HOLD;
				end
				default: begin
				end
			endcase
		end else if (lnk.frame_end) begin
			fr_d  = SFSR_FR_IDLE;
			txe_d = 1'b0;
			if (fr_q == SFSR_FR_HOLD) begin
				if (cmd_q != SFSR_CMD_VOLATILE_ENABLE) begin
					vwe_d = 1'b0;
				end
				if (cmd_q != SFSR_CMD_RESET_ENABLE) begin
					rsten_d = 1'b0;
				end
				if (cmd_q == SFSR_CMD_WRITE_ENABLE) begin
					st_d[SFSR_BIT_WR_LATCH] = 1'b1;         // see [R4]
				end else if (cmd_q == SFSR_CMD_WRITE_DISABLE) begin
					st_d[SFSR_BIT_WR_LATCH] = 1'b0;         // see [R15]
				end else if (cmd_q == SFSR_CMD_VOLATILE_ENABLE) begin
					vwe_d = 1'b1;
				end else if (cmd_q == SFSR_CMD_RESET_ENABLE) begin
					rsten_d = 1'b1;
				end else if (cmd_q == SFSR_CMD_RESET && rsten_q) begin
					srst_d = 1'b1;
				end else if (cmd_q == SFSR_CMD_SUSPEND && arb_q) begin
					arb_d = 1'b0;                           // see [R17]
					sus_d = 1'b1;
					if (are_q) begin
						st_d[SFSR_BIT_ERAS_SUS] = 1'b1;     // see [R10]
					end else begin
						st_d[SFSR_BIT_PROG_SUS] = 1'b1;     // see [R8]
					end
				end else if (cmd_q == SFSR_CMD_RESUME && !busy
						&& (st_q[SFSR_BIT_PROG_SUS]
						|| st_q[SFSR_BIT_ERAS_SUS])) begin
					arb_d = 1'b1;                           // see [R17]
					res_d = 1'b1;
					st_d[SFSR_BIT_PROG_SUS] = 1'b0;
					st_d[SFSR_BIT_ERAS_SUS] = 1'b0;
				end else if (lane != 2'h3 && dok_q) begin
					// latch and one-time bits only ever stay or set
					lmask = SFSR_WRITE_MASK & sfsr_place(8'hFF, lane);
					cand  = (st_q & ~lmask)
						| (sfsr_place(dat_q, lane) & lmask)
						| (st_q & SFSR_OTP_MASK);           // see [R9]
					if (cand != st_q) begin                 // see [R2]
						if (vwe_q) begin
							st_d = cand;                    // see [R5] [R7]
						end else if (st_q[SFSR_BIT_WR_LATCH]) begin
							st_d  = cand;                   // see [R6] [R13]
							nv_d  = cand;
							nvb_d = 1'b1;
							cnt_d = SFSR_WCNT_W'(WRITE_CYCLES - 1);
						end
					end
				end
			end
		end

		// refresh the read byte at each byte boundary for live polling
		if (txe_d && (lnk.rx_valid || !txe_q)) begin
			rsel  = cmd_d;
			case (sfsr_lane(rsel))
				2'h0: txb_d = word[7:0];
				2'h1: txb_d = word[15:8];
				default: txb_d = word[23:16];
			endcase
		end

		// the protection hit sets late, but a same-cycle reset still clears it
		if (prot_hit_i) begin
			st_d[SFSR_BIT_PROT_HIT] = 1'b1;             // see [R11]
		end

		// software or pin reset: volatile copies reload, flags drop
		if (srst_d || hw_rst) begin
			st_d  = (st_q & ~SFSR_DUAL_MASK & ~SFSR_VOL_CLR_MASK)
				| (nv_q & SFSR_DUAL_MASK);              // see [R18]
			nvb_d = 1'b0;
			arb_d = 1'b0;
			vwe_d = 1'b0;
			rsten_d = 1'b0;
			srst_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			fr_q    <= SFSR_FR_IDLE;
			cmd_q   <= 8'h00;
			dat_q   <= 8'h00;
			dok_q   <= 1'b0;
			txe_q   <= 1'b0;
			txb_q   <= 8'h00;
			vwe_q   <= 1'b0;
			rsten_q <= 1'b0;
			st_q    <= SFSR_STATUS_RESET;               // see [R18]
			nv_q    <= SFSR_STATUS_RESET;
			nvb_q   <= 1'b0;
			arb_q   <= 1'b0;
			are_q   <= 1'b0;
			cnt_q   <= '0;
			sus_q   <= 1'b0;
			res_q   <= 1'b0;
			srst_q  <= 1'b0;
		end else begin
			fr_q    <= fr_d;
			cmd_q   <= cmd_d;
			dat_q   <= dat_d;
			dok_q   <= dok_d;
			txe_q   <= txe_d;
			txb_q   <= txb_d;
			vwe_q   <= vwe_d;
			rsten_q <= rsten_d;
			st_q    <= st_d;
			nv_q    <= nv_d;
			nvb_q   <= nvb_d;
			arb_q   <= arb_d;
			are_q   <= are_d;
			cnt_q   <= cnt_d;
			sus_q   <= sus_d;
			res_q   <= res_d;
			srst_q  <= srst_d;
		end
	end

	// ==========================================================
	// outputs
	assign lnk.tx_en            = txe_q;
	assign lnk.tx_byte          = txb_q;
	assign busy_o               = busy;
	assign write_enable_latch_o = st_q[SFSR_BIT_WR_LATCH];
	assign block_protect_o      = st_q[SFSR_BIT_BP_LSB +: 5];
	assign status_protect_o     = st_q[SFSR_BIT_SRP_LSB +: 2];
	assign quad_enable_o        = st_q[SFSR_BIT_QUAD];
	assign info_lock_o          = st_q[SFSR_BIT_IRL_LSB +: 3];
	assign complement_protect_o = st_q[SFSR_BIT_COMPL];
	assign drive_strength_o     = st_q[SFSR_BIT_ODS_LSB +: 2];
	assign hold_reset_sel_o     = st_q[SFSR_BIT_HOLD_RST];
	assign suspend_o            = sus_q;
	assign resume_o             = res_q;
	assign soft_reset_o         = srst_q;
endmodule

/* File: sim/sfsr_checker.sv */
module sfsr_checker (
	// clock and reset
	input wire logic       clk_sys_i,
	input wire logic       nrst_i,
	// pins and array events
	input wire logic       cs_n_i,
	input wire logic       so_oe_o,
	input wire logic       op_start_i,
	input wire logic       op_done_i,
	// status outputs
	input wire logic       busy_o,
	input wire logic       write_enable_latch_o,
	input wire logic [4:0] block_protect_o,
	input wire logic [1:0] status_protect_o,
	input wire logic       quad_enable_o,
	input wire logic [2:0] info_lock_o,
	input wire logic       complement_protect_o,
	input wire logic [1:0] drive_strength_o,
	input wire logic       hold_reset_sel_o,
	input wire logic       suspend_o,
	input wire logic       resume_o,
	input wire logic       soft_reset_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	// ==========================================================
	// assertions
	a_reset_config: assert property (
		$rose(nrst_i) |-> {block_protect_o, status_protect_o,
		quad_enable_o, complement_protect_o, drive_strength_o,
		hold_reset_sel_o} == 12'h004)
		else $error("config outputs wrong after reset");
	a_reset_flags: assert property (
		$rose(nrst_i) |-> !busy_o && !write_enable_latch_o
		&& info_lock_o == 3'h0)
		else $error("flags wrong after reset");
	a_start_busy: assert property (
		op_start_i |=> busy_o [*2])
		else $error("busy missing after op start");
	a_done_idle: assert property (
		op_done_i |=> !busy_o)
		else $error("busy stuck after op done");
	a_done_latch: assert property (
		op_done_i |=> !write_enable_latch_o)
		else $error("latch kept after op done");
	// latch may only be set once the frame is closed
	a_latch_at_end: assert property (
		$rose(write_enable_latch_o) |-> cs_n_i && $past(cs_n_i, 2))
		else $error("latch set inside a frame");
	a_lock_sticky: assert property (
		(~info_lock_o & $past(info_lock_o)) == 3'h0)
		else $error("lock bit cleared");
	a_suspend_busy: assert property (
		suspend_o |-> $past(busy_o, 2))
		else $error("suspend while idle");
	a_resume_idle: assert property (
		resume_o |-> !$past(busy_o, 2))
		else $error("resume while busy");
	a_reset_clears: assert property (
		soft_reset_o |-> ##[0:2] !write_enable_latch_o && !busy_o)
		else $error("reset left latch or busy");
	// enable may trail the frame end by the two synchroniser stages
	a_oe_framed: assert property (
		so_oe_o |-> !$past(cs_n_i, 2))
		else $error("output enabled outside a frame");

	// ==========================================================
	// coverage
	c_op: cover property (op_start_i);
	c_susp: cover property (suspend_o);
	c_sreset: cover property (soft_reset_o);
	c_latch: cover property ($rose(write_enable_latch_o));
endmodule

bind sfsr_top sfsr_checker u_chk (.clk_sys_i, .nrst_i, .cs_n_i, .so_oe_o,
	.op_start_i, .op_done_i, .busy_o, .write_enable_latch_o,
	.block_protect_o, .status_protect_o, .quad_enable_o, .info_lock_o,
	.complement_protect_o, .drive_strength_o, .hold_reset_sel_o,
	.suspend_o, .resume_o, .soft_reset_o);

/* File: sim/sfsr_spi_host.sv */
module sfsr_spi_host (
	// serial pins
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      si_o,
	input  wire logic so_i
);
	timeunit 1ns;
	timeprecision 1ps;
	import sfsr_pkg::*;
	localparam time HALF = 160ns;

	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end

	// ==========================================================
	// mode 0 byte shift, msb first, sample on rise
	task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			si_o = tx[i];
			#HALF sck_o = 1'b1;
			rx[i] = so_i;
			#HALF sck_o = 1'b0;
		end
	endtask

	// odd start offset keeps the link unrelated in phase to clk
	task automatic frame(input logic [7:0] c, input logic dat,
			input logic [7:0] wd, output logic [7:0] rd);
		logic [7:0] junk;
		#13 cs_n_o = 1'b0;
		#HALF;
		shift(c, junk);
		rd = 8'h00;
		if (dat) begin
			shift(wd, rd);
		end
		#HALF cs_n_o = 1'b1;
		si_o = ~si_o;
		#(4 * HALF);
	endtask

	// poll busy before the next command, bounded
	task automatic wait_ready();
		logic [7:0] st;
		int n;
		st = 8'h01;
		n = 0;
		while (st[0] === 1'b1 && n < 50) begin
			frame(SFSR_CMD_READ_LOW, 1'b1, 8'h00, st);
			n++;
		end
	endtask
endmodule

/* File: sim/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sfsr_pkg::*;
	// long enough that a read frame sees the write still busy
	localparam int WCYC = 400;
	logic       clk_sys_i = 1'b0;
	logic       nrst_i = 1'b0;
	logic       sck, cs_n, si, so, oe, so_pin, busy, wr_lat;
	logic       hold_rst_n_i = 1'b1;
	logic       op_start_i = 1'b0, op_erase_i = 1'b0;
	logic       op_done_i = 1'b0, op_fail_i = 1'b0, prot_hit_i = 1'b0;
	logic [1:0] drv;
	int         err_total = 0;
	int         n_compared = 0;

	always #20 clk_sys_i = ~clk_sys_i;

	// released pin reads inverted, so a late or missing enable shows up
	assign so_pin = oe ? so : ~so;

	sfsr_spi_host host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so_pin));

	sfsr_top #(.WRITE_CYCLES(WCYC)) dut (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sck_i(sck),
		.cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(oe),
		.hold_rst_n_i(hold_rst_n_i), .op_start_i(op_start_i),
		.op_erase_i(op_erase_i), .op_done_i(op_done_i),
		.op_fail_i(op_fail_i), .prot_hit_i(prot_hit_i),
		.busy_o(busy), .write_enable_latch_o(wr_lat),
		.block_protect_o(), .status_protect_o(), .quad_enable_o(),
		.info_lock_o(), .complement_protect_o(),
		.drive_strength_o(drv), .hold_reset_sel_o(), .suspend_o(),
		.resume_o(), .soft_reset_o());

	// ==========================================================
	// helpers
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] e,
			input string w);
		n_compared++;
		if (got !== e) begin
			err_total++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, w, got, e);
		end
	endtask

	task automatic rchk(input logic [7:0] c, input logic [7:0] e,
			input string w);
		logic [7:0] v;
		host.frame(c, 1'b1, 8'h00, v);
		chk(v, e, w);
	endtask

	task automatic cmd(input logic [7:0] c);
		logic [7:0] v;
		host.frame(c, 1'b0, 8'h00, v);
	endtask

	task automatic wnv(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] v;
		cmd(SFSR_CMD_WRITE_ENABLE);
		host.frame(c, 1'b1, d, v);
		host.wait_ready();
	endtask

	// one-cycle event: {start, erase, done, fail, prot}
	task automatic ev(input logic [4:0] e);
		@(negedge clk_sys_i);
		{op_start_i, op_erase_i, op_done_i, op_fail_i, prot_hit_i} = e;
		@(negedge clk_sys_i);
		{op_start_i, op_erase_i, op_done_i, op_fail_i, prot_hit_i} = 5'h00;
		repeat (4) @(negedge clk_sys_i);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		rchk(SFSR_CMD_READ_LOW, 8'h00, "low");
		rchk(SFSR_CMD_READ_MID, 8'h00, "mid");
		rchk(SFSR_CMD_READ_HIGH, 8'h40, "high");
		chk({6'h00, drv}, 8'h02, "drive pins");
		$display("test reset done");
	endtask

	task automatic t_latch();
		cmd(SFSR_CMD_WRITE_ENABLE);
		rchk(SFSR_CMD_READ_LOW, 8'h02, "latch set");
		chk({7'h00, wr_lat}, 8'h01, "latch pin");
		cmd(SFSR_CMD_WRITE_DISABLE);
		rchk(SFSR_CMD_READ_LOW, 8'h00, "latch clear");
		$display("test latch done");
	endtask

	task automatic t_nv();
		logic [7:0] v;
		cmd(SFSR_CMD_WRITE_ENABLE);
		host.frame(SFSR_CMD_WRITE_LOW, 1'b1, 8'hFF, v);
		host.frame(SFSR_CMD_READ_LOW, 1'b1, 8'h00, v);
		chk(v & 8'h03, 8'h03, "busy in write");
		host.wait_ready();
		rchk(SFSR_CMD_READ_LOW, 8'hFC, "low");
		wnv(SFSR_CMD_WRITE_LOW, 8'hFC);
		rchk(SFSR_CMD_READ_LOW, 8'hFE, "same value");
		cmd(SFSR_CMD_WRITE_DISABLE);
		wnv(SFSR_CMD_WRITE_MID, 8'hFF);
		rchk(SFSR_CMD_READ_MID, 8'h7B, "mid");
		wnv(SFSR_CMD_WRITE_HIGH, 8'hFF);
		rchk(SFSR_CMD_READ_HIGH, 8'hE0, "high");
		wnv(SFSR_CMD_WRITE_MID, 8'h00);
		rchk(SFSR_CMD_READ_MID, 8'h38, "locks kept");
		$display("test nv write done");
	endtask

	task automatic t_vol();
		logic [7:0] v;
		cmd(SFSR_CMD_VOLATILE_ENABLE);
		host.frame(SFSR_CMD_WRITE_LOW, 1'b1, 8'h84, v);
		rchk(SFSR_CMD_READ_LOW, 8'h84, "volatile");
		cmd(SFSR_CMD_RESET_ENABLE);
		cmd(SFSR_CMD_RESET);
		rchk(SFSR_CMD_READ_LOW, 8'hFC, "reload");
		$display("test volatile done");
	endtask

	task automatic t_array();
		ev(5'h10);
		chk({7'h00, busy}, 8'h01, "busy pin");
		cmd(SFSR_CMD_WRITE_ENABLE);
		rchk(SFSR_CMD_READ_LOW, 8'hFD, "ignored");
		cmd(SFSR_CMD_SUSPEND);
		rchk(SFSR_CMD_READ_MID, 8'h3C, "prog susp");
		cmd(SFSR_CMD_RESUME);
		rchk(SFSR_CMD_READ_MID, 8'h38, "resumed");
		ev(5'h01);
		ev(5'h06);
		rchk(SFSR_CMD_READ_HIGH, 8'hEC, "errors");
		rchk(SFSR_CMD_READ_LOW, 8'hFC, "ready");
		ev(5'h18);
		cmd(SFSR_CMD_SUSPEND);
		rchk(SFSR_CMD_READ_MID, 8'hB8, "erase susp");
		cmd(SFSR_CMD_RESUME);
		ev(5'h04);
		rchk(SFSR_CMD_READ_HIGH, 8'hE4, "fail cleared");
		@(negedge clk_sys_i);
		hold_rst_n_i = 1'b0;
		repeat (6) @(negedge clk_sys_i);
		hold_rst_n_i = 1'b1;
		repeat (8) @(negedge clk_sys_i);
		rchk(SFSR_CMD_READ_HIGH, 8'hE0, "pin reset");
		$display("test array done");
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		repeat (8) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		t_reset();
		t_latch();
		t_nv();
		t_vol();
		t_array();
		summarize();
	end

	initial begin
		#2ms;
		err_total++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		summarize();
	end
endmodule
